// ### inc/fiq_vec_defines.vh
`ifndef FIQ_VEC_DEFINES_VH
`define FIQ_VEC_DEFINES_VH

// Register byte addresses
`define ADDR_VECTOR_BASE 32'hffff0014
`define ADDR_VECTOR_POINTER 32'hffff001c
`define ADDR_NESTING_CONTROL 32'hffff0030
`define ADDR_PRIORITY_A 32'hffff0020
`define ADDR_PRIORITY_B 32'hffff0024
`define ADDR_PRIORITY_C 32'hffff0028
`define ADDR_NORMAL_STATUS 32'hffff0000
`define ADDR_NORMAL_RAW 32'hffff0004
`define ADDR_NORMAL_ENABLE 32'hffff0008
`define ADDR_NORMAL_CLEAR 32'hffff000c
`define ADDR_FAST_STATUS 32'hffff0100
`define ADDR_FAST_RAW 32'hffff0104
`define ADDR_FAST_ENABLE 32'hffff0108
`define ADDR_FAST_CLEAR 32'hffff010c
`define ADDR_SOFT_CONFIG 32'hffff0110

// Reset values
`define RST_ZERO32 32'h00000000
`define RST_BASE16 16'h0000
`define RST_PRIO3 3'h0

// Field positions
`define SOFT_FAST_BIT 2
`define SOFT_NORMAL_BIT 1
`define SOFT_SRC_BIT 1
`define FAST_SRC_BIT 0
`define NEST_NORMAL_BIT 0
`define NEST_FAST_BIT 1
`define VEC_BASE_LSB 7
`define VEC_BASE_MSB 22
`define VEC_IDX_LSB 2
`define VEC_IDX_MSB 6

// Vectoring
`define NUM_NORMAL_SRC 22
`define NUM_PRIO_SLOTS 24
`define PRIO_LEVELS 8

`endif

// ### hw/prio_store.v
`timescale 1ns/1ps
// Priority level storage, registered read
module prio_store (
    input wire clk_in,
    input wire rst_b_in,
    input wire wr_en_in,
    input wire [1:0] wr_sel_in,
    input wire [31:0] wr_data_in,
    input wire [1:0] rd_sel_in,
    output reg [31:0] rd_data_out,
    output wire [71:0] levels_out
);
    reg [31:0] mem_reg [0:2];
    reg [71:0] levels_next;
    wire [95:0] words;
    integer i;
    integer k;

    assign words = {mem_reg[2], mem_reg[1], mem_reg[0]};

    // Three-bit level per source, one nibble per source
    always @* begin
        levels_next = 72'h000000000000000000;
        for (k = 0; k < 24; k = k + 1) begin
            levels_next[k*3 +: 3] = words[k*4 +: 3];
        end
    end

    assign levels_out = levels_next;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (i = 0; i < 3; i = i + 1) begin
                mem_reg[i] <= 32'h00000000;
            end
            rd_data_out <= 32'h00000000;
        end else begin
            if (wr_en_in && wr_sel_in != 2'h3) begin
                mem_reg[wr_sel_in] <= wr_data_in & ((wr_sel_in == 2'h2) ? 32'h00777777 :
                    (wr_sel_in == 2'h1) ? 32'h77777777 : 32'h77777770);
            end
            rd_data_out <= (rd_sel_in == 2'h3) ? 32'h00000000 : mem_reg[rd_sel_in];
        end
    end
endmodule // prio_store

// ### hw/fast_interrupt_and_vector_unit.v
`timescale 1ns/1ps
`include "fiq_vec_defines.vh"
module fast_interrupt_and_vector_unit (
    input wire clk_in,
    input wire rst_b_in,
    input wire [31:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire [31:0] fast_src_in,
    input wire [31:0] normal_src_in,
    output wire fast_req_out,
    output wire normal_req_out,
    output wire vectored_fast_out,
    output wire vectored_normal_out
);
    reg rst_meta_reg;
    reg rst_sync_reg;
    reg [31:0] fast_en_reg;
    reg [31:0] normal_en_reg;
    reg [2:0] soft_cfg_reg;
    reg [1:0] nest_reg;
    reg [15:0] base_reg;
    reg [31:0] rdata_next;
    reg [31:0] rdata_reg;
    reg rd_prio_reg;
    wire [31:0] fast_raw;
    wire [31:0] normal_raw;
    wire [31:0] fast_sta;
    wire [31:0] normal_sta;
    wire fast_or;
    wire [31:0] prio_rdata;
    wire [71:0] levels;
    wire prio_wr;
    wire [1:0] prio_sel;
    wire [4:0] best_idx;
    wire [31:0] vec_ptr;

    // Reset release
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Highest priority active normal source, lowest index wins ties
    function [4:0] pick_best;
        input [31:0] sta;
        input [71:0] lv;
        integer k;
        reg [2:0] best_lv;
        reg found;
        begin
            pick_best = 5'h00;
            best_lv = 3'h0;
            found = 1'b0;
            for (k = 0; k < `NUM_NORMAL_SRC; k = k + 1) begin
                if (sta[k] && (!found || lv[k*3 +: 3] > best_lv)) begin
                    pick_best = k[4:0];
                    best_lv = lv[k*3 +: 3];
                    found = 1'b1;
                end
            end
        end
    endfunction

    // Raw sources with soft and fast-summary bits forced
    assign fast_raw = {fast_src_in[31:2], soft_cfg_reg[`SOFT_FAST_BIT], fast_or};
    assign normal_raw = {normal_src_in[31:2], soft_cfg_reg[`SOFT_NORMAL_BIT], fast_or};
    // Soft bit bypasses masks
    assign fast_sta = {fast_src_in[31:2] & fast_en_reg[31:2],
                       soft_cfg_reg[`SOFT_FAST_BIT], 1'b0};
    assign normal_sta = {normal_src_in[31:2] & normal_en_reg[31:2],
                         soft_cfg_reg[`SOFT_NORMAL_BIT], fast_or & normal_en_reg[0]};
    assign fast_or = |fast_sta[31:1];
    assign fast_req_out = fast_or;
    assign normal_req_out = (|normal_sta) & ~fast_or;
    assign vectored_fast_out = nest_reg[`NEST_FAST_BIT];
    assign vectored_normal_out = nest_reg[`NEST_NORMAL_BIT];

    assign prio_wr = wr_in && (addr_in == `ADDR_PRIORITY_A || addr_in == `ADDR_PRIORITY_B ||
                               addr_in == `ADDR_PRIORITY_C);
    assign prio_sel = (addr_in == `ADDR_PRIORITY_A) ? 2'h0 :
                      (addr_in == `ADDR_PRIORITY_B) ? 2'h1 :
                      (addr_in == `ADDR_PRIORITY_C) ? 2'h2 : 2'h3;

    prio_store u_prio (
        .clk_in(clk_in),
        .rst_b_in(rst_sync_reg),
        .wr_en_in(prio_wr),
        .wr_sel_in(prio_sel),
        .wr_data_in(wdata_in),
        .rd_sel_in(prio_sel),
        .rd_data_out(prio_rdata),
        .levels_out(levels)
    );

    assign best_idx = pick_best(normal_sta, levels);
    assign vec_ptr = {9'h000, base_reg, best_idx, 2'h0};

    // Register writes
    always @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            fast_en_reg <= `RST_ZERO32;
            normal_en_reg <= `RST_ZERO32;
            soft_cfg_reg <= 3'h0;
            nest_reg <= 2'h0;
            base_reg <= `RST_BASE16;
        end else if (wr_in) begin
            case (addr_in)
                `ADDR_FAST_ENABLE: begin
                    fast_en_reg <= fast_en_reg | wdata_in;
                    normal_en_reg <= normal_en_reg & ~wdata_in;
                end
                `ADDR_FAST_CLEAR: fast_en_reg <= fast_en_reg & ~wdata_in;
                `ADDR_NORMAL_ENABLE: begin
                    normal_en_reg <= normal_en_reg | wdata_in;
                    fast_en_reg <= fast_en_reg & ~wdata_in;
                end
                `ADDR_NORMAL_CLEAR: normal_en_reg <= normal_en_reg & ~wdata_in;
                `ADDR_SOFT_CONFIG: soft_cfg_reg <= {wdata_in[2:1], 1'b0};
                `ADDR_NESTING_CONTROL: nest_reg <= wdata_in[1:0];
                `ADDR_VECTOR_BASE: base_reg <= wdata_in[15:0];
                default: base_reg <= base_reg;
            endcase
        end
    end

    // Read mux
    always @* begin
        case (addr_in)
            `ADDR_FAST_STATUS: rdata_next = fast_sta;
            `ADDR_FAST_RAW: rdata_next = fast_raw;
            `ADDR_FAST_ENABLE: rdata_next = fast_en_reg;
            `ADDR_NORMAL_STATUS: rdata_next = normal_sta;
            `ADDR_NORMAL_RAW: rdata_next = normal_raw;
            `ADDR_NORMAL_ENABLE: rdata_next = normal_en_reg;
            `ADDR_SOFT_CONFIG: rdata_next = {29'h00000000, soft_cfg_reg};
            `ADDR_NESTING_CONTROL: rdata_next = {30'h00000000, nest_reg};
            `ADDR_VECTOR_BASE: rdata_next = {16'h0000, base_reg};
            `ADDR_VECTOR_POINTER: rdata_next = vec_ptr;
            default: rdata_next = `RST_ZERO32;
        endcase
    end

    always @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rdata_reg <= `RST_ZERO32;
            rd_prio_reg <= 1'b0;
        end else begin
            rd_prio_reg <= rd_in && prio_sel != 2'h3;
            rdata_reg <= rd_in ? rdata_next : `RST_ZERO32;
        end
    end

    // Priority words come from the store's own read register
    always @* begin
        rdata_out = rd_prio_reg ? prio_rdata : rdata_reg;
    end
endmodule // fast_interrupt_and_vector_unit

// ### verification/fiv_checker.sv
`timescale 1ns/1ps
`include "fiq_vec_defines.vh"
module fiv_checker (
    input wire clk_in,
    input wire rst_b_in,
    input wire [31:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire [31:0] fast_src_in,
    input wire fast_req_out,
    input wire normal_req_out,
    input wire vectored_fast_out,
    input wire vectored_normal_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire rs = rd_in && addr_in == `ADDR_FAST_STATUS;
    property p_clr; rd_in && addr_in == `ADDR_FAST_CLEAR |=> rdata_out == 32'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear read");
    property p_bhi; rd_in && addr_in == `ADDR_VECTOR_BASE |=> rdata_out[31:16] == 16'h0; endproperty
    a_bhi: assert property (p_bhi) else $error("base upper");
    property p_vz; rd_in && addr_in == `ADDR_VECTOR_POINTER
        |=> rdata_out[31:23] == 9'h0 && rdata_out[1:0] == 2'h0; endproperty
    a_vz: assert property (p_vz) else $error("pointer zero bits");
    property p_pri; fast_req_out |-> !normal_req_out; endproperty
    a_pri: assert property (p_pri) else $error("fast precedence");
    property p_and; rs && $stable(fast_src_in) && fast_src_in == $past(fast_src_in, 2)
        |=> (rdata_out[31:2] & ~$past(fast_src_in[31:2])) == 30'h0; endproperty
    a_and: assert property (p_and) else $error("status not in raw");
    property p_or; rs |=> (|rdata_out[31:1]) == $past(fast_req_out); endproperty
    a_or: assert property (p_or) else $error("request vs status");
    property p_nest; wr_in && addr_in == `ADDR_NESTING_CONTROL
        |=> {vectored_fast_out, vectored_normal_out} == $past(wdata_in[1:0]); endproperty
    a_nest: assert property (p_nest) else $error("nesting bits");
    property p_base; wr_in && addr_in == `ADDR_VECTOR_BASE ##2 rd_in && addr_in == `ADDR_VECTOR_BASE
        |=> rdata_out == {16'h0, $past(wdata_in[15:0], 3)}; endproperty
    a_base: assert property (p_base) else $error("base readback");
endmodule // fiv_checker
bind fast_interrupt_and_vector_unit fiv_checker u_chk (.*);

// ### verification/core_model.sv
`timescale 1ns/1ps
// Core side: 2 fast taken, 1 normal taken, 0 idle
module core_model (
    input wire clk_in,
    input wire fast_req_in,
    input wire normal_req_in,
    output reg [1:0] mode_out
);
    always @(posedge clk_in) begin
        mode_out <= fast_req_in ? 2'h2 : (normal_req_in ? 2'h1 : 2'h0);
    end
endmodule // core_model

// ### verification/fast_interrupt_and_vector_unit_tb_top.sv
`timescale 1ns/1ps
`include "fiq_vec_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module fast_interrupt_and_vector_unit_tb_top;
    reg clk_in = 0, rst_b_in = 0, wr_in = 0, rd_in = 0;
    reg [31:0] addr_in = 0, wdata_in = 0, fast_src_in = 0, normal_src_in = 0;
    reg [31:0] s, m, c;
    wire [31:0] rdata_out;
    wire fast_req_out, normal_req_out, vf, vn;
    wire [1:0] mode;
    int mismatches = 0, checks = 0, i;
    reg [31:0] ra [0:6] = '{`ADDR_VECTOR_BASE, `ADDR_VECTOR_POINTER, `ADDR_FAST_STATUS,
        `ADDR_FAST_RAW, `ADDR_FAST_ENABLE, `ADDR_FAST_CLEAR, 32'hffff0200};
    fast_interrupt_and_vector_unit uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .fast_src_in(fast_src_in), .normal_src_in(normal_src_in),
        .fast_req_out(fast_req_out), .normal_req_out(normal_req_out),
        .vectored_fast_out(vf), .vectored_normal_out(vn));
    core_model cm (.clk_in(clk_in), .fast_req_in(fast_req_out),
        .normal_req_in(normal_req_out), .mode_out(mode));
    initial forever #50 clk_in = ~clk_in;
    function automatic [31:0] st(input [31:0] src, input [31:0] mk);
        st = src & mk & 32'hfffffffc;
    endfunction
    task wr(input [31:0] a, input [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task rdc(input [31:0] a, input [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        `CHK(rdata_out, e)
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        test_done;
    end
    initial begin
        void'($urandom(41309));
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        for (i = 0; i < 7; i++) rdc(ra[i], 32'h0);
        $display("reset test done");
        for (i = 0; i < 5; i++) begin
            s = (i == 0) ? 32'hfffffffc : $urandom & 32'hfffffffc;
            m = (i == 0) ? 32'h0 : $urandom & 32'hfffffffc;
            c = $urandom;
            fast_src_in <= s;
            wr(`ADDR_NORMAL_ENABLE, 32'hffffffff);
            wr(`ADDR_FAST_ENABLE, m);
            wr(`ADDR_FAST_ENABLE, 32'h0);
            rdc(`ADDR_FAST_ENABLE, m);
            rdc(`ADDR_NORMAL_ENABLE, ~m);
            rdc(`ADDR_FAST_RAW, s | {31'h0, |st(s, m)});
            rdc(`ADDR_FAST_STATUS, st(s, m));
            `CHK(fast_req_out, |st(s, m))
            fast_src_in <= s & ~c;
            wr(`ADDR_FAST_CLEAR, c);
            rdc(`ADDR_FAST_CLEAR, 32'h0);
            rdc(`ADDR_FAST_ENABLE, m & ~c);
            `CHK(fast_req_out, |st(s & ~c, m & ~c))
        end
        $display("mask test done");
        fast_src_in <= 32'h0;
        wr(`ADDR_FAST_CLEAR, 32'hffffffff);
        wr(`ADDR_SOFT_CONFIG, 32'h4);
        rdc(`ADDR_FAST_STATUS, 32'h2);
        rdc(`ADDR_FAST_RAW, 32'h3);
        `CHK({fast_req_out, normal_req_out, mode}, 4'ha)
        wr(`ADDR_SOFT_CONFIG, 32'h2);
        rdc(`ADDR_NORMAL_RAW, 32'h2);
        `CHK({fast_req_out, normal_req_out, mode}, 4'h5)
        $display("soft test done");
        wr(`ADDR_NESTING_CONTROL, 32'h3);
        `CHK({vf, vn}, 2'h3)
        wr(`ADDR_VECTOR_BASE, 32'hffffbeef);
        rdc(`ADDR_VECTOR_BASE, 32'h0000beef);
        rdc(`ADDR_VECTOR_POINTER, {9'h0, 16'hbeef, 5'h01, 2'h0});
        normal_src_in <= 32'h00020020;
        wr(`ADDR_NORMAL_ENABLE, 32'h00020020);
        wr(`ADDR_PRIORITY_A, 32'h00200010);
        wr(`ADDR_PRIORITY_B, 32'hffffffff);
        wr(`ADDR_PRIORITY_C, 32'hffffff30);
        rdc(`ADDR_PRIORITY_A, 32'h00200010);
        rdc(`ADDR_PRIORITY_B, 32'h77777777);
        rdc(`ADDR_PRIORITY_C, 32'h00777730);
        wr(`ADDR_PRIORITY_C, 32'h00000030);
        rdc(`ADDR_VECTOR_POINTER, {9'h0, 16'hbeef, 5'h11, 2'h0});
        $display("priority test done");
        normal_src_in <= 32'h0;
        wr(`ADDR_SOFT_CONFIG, 32'h0);
        `CHK({fast_req_out, normal_req_out}, 2'h0)
        $display("vector test done");
        test_done;
    end
endmodule // fast_interrupt_and_vector_unit_tb_top
